/* rtl/window_watchdog_regs.vh */
`ifndef WINDOW_WATCHDOG_REGS_VH
`define WINDOW_WATCHDOG_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WWD_OFS_WINDOW_CFG 8'h1c
`define WWD_OFS_OUTPUT_CFG 8'h1d
`define WWD_OFS_STATUS 8'h1e
`define WWD_OFS_SWRESET 8'h1f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WWD_RST_WINDOW_CFG 8'h00
`define WWD_RST_OUTPUT_CFG 8'h01
`define WWD_RST_STATUS 8'h00
`define WWD_RST_SWRESET 8'h00

// ----------------------------------------
// Field positions, window config
// ----------------------------------------
`define WWD_CLOSE_HI 7
`define WWD_CLOSE_LO 6
`define WWD_OPEN_HI 5
`define WWD_OPEN_LO 4
`define WWD_LONG_HI 3
`define WWD_LONG_LO 2
`define WWD_THR_HI 1
`define WWD_THR_LO 0

// ----------------------------------------
// Field positions, output config
// ----------------------------------------
`define WWD_LOCK_BIT 7
`define WWD_RSV2_HI 6
`define WWD_RSV2_LO 5
`define WWD_FLAGMODE_BIT 4
`define WWD_NVRELOAD_BIT 3
`define WWD_PULLDOWN_BIT 2
`define WWD_POL_BIT 1
`define WWD_DRIVE_BIT 0

// ----------------------------------------
// Field positions, status and software reset
// ----------------------------------------
`define WWD_RSV3_HI 7
`define WWD_RSV3_LO 5
`define WWD_FLAGCLR_BIT 4
`define WWD_FLAG_BIT 3
`define WWD_CNTCLR_BIT 2
`define WWD_SWRST_BIT 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define WWD_CLK_HZ 10000000
`define WWD_MS_PER_S 1000
`define WWD_CLOSE_MS_0 10
`define WWD_CLOSE_MS_1 20
`define WWD_CLOSE_MS_2 50
`define WWD_CLOSE_MS_3 100
`define WWD_OPEN_MS_0 20
`define WWD_OPEN_MS_1 100
`define WWD_OPEN_MS_2 200
`define WWD_OPEN_MS_3 600
`define WWD_LONG_MS_0 200
`define WWD_LONG_MS_1 600
`define WWD_LONG_MS_2 2000
`define WWD_LONG_MS_3 5000
`define WWD_PULSE_CYCLES 16

`endif

/* rtl/wwd_input_sync.v */
`timescale 1ns/1ns
module wwd_input_sync (
  // Clock and reset
  input wire CLK_SYS,
  input wire RST,
  input wire CE,
  // Pin and filtered level
  input wire PIN_IN,
  output reg LEVEL_OUT
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  // ----------------------------------------
  // Three stage capture, accept when last two agree
  // ----------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      LEVEL_OUT <= 1'b0;
    end else if (CE) begin
      s1_ff <= PIN_IN;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        LEVEL_OUT <= s3_ff;
      end
    end
  end

endmodule // wwd_input_sync

/* rtl/window_watchdog_control.v */
// Summary of operation
// - Closed window 10/20/50/100 ms by code
// - Open window 20/100/200/600 ms by code
// - Long window 200/600/2000/5000 ms by code
// - Restart when pulse count hits threshold
// - Lock bit blocks writes to controls
// - Only reset or software reset clears the lock
// - Status stays writable while locked
// - Counter valid only for codes 00, 11
// - Flag mode 1 blocks further restarts
// - Option bit reloads nonvolatile on restart
// - Pull-down select drives trigger pull-down
// - Polarity bit chooses reset output level
// - Drive bit chooses push-pull or open-drain
// - Restart sets flag, cleared by clear bit
// - Flag clear bit pulses, then reads 0
// - Counter clear bit pulses counter clear
// - Counter value readable in status bits
// - Software reset restores defaults, reloads nonvolatile
// - Software reset bit self clears
// - Config defaults load from nonvolatile memory
`timescale 1ns/1ns
`include "window_watchdog_regs.vh"
module window_watchdog_control #(
  parameter CYCLES_PER_MS = `WWD_CLK_HZ / `WWD_MS_PER_S,
  parameter PULSE_CYCLES = `WWD_PULSE_CYCLES
) (
  // Clock, reset, enable
  input wire CLK_SYS,
  input wire RST,
  input wire CE,
  // Register port
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  // Nonvolatile defaults
  input wire [7:0] NV_WINDOW_CFG,
  input wire [7:0] NV_OUTPUT_CFG,
  output reg NV_LOAD_REQ,
  // Watchdog pins
  input wire WATCHDOG_TRIGGER_INPUT,
  output reg TRIGGER_PULLDOWN_EN,
  output reg WATCHDOG_RESET_OUTPUT,
  output reg WATCHDOG_RESET_OE_N,
  // System restart
  output reg RESTART_REQ,
  output reg PULSE_COUNT_VALID
);

  localparam ST_LONG = 2'b00;
  localparam ST_CLOSE = 2'b01;
  localparam ST_OPEN = 2'b10;
  localparam ST_PULSE = 2'b11;

  reg [7:0] window_cfg_ff;
  reg [7:0] output_cfg_ff;
  reg [2:0] status_rsv_ff;
  reg [6:0] swrst_rsv_ff;
  reg flag_ff;
  reg flag_clr_ff;
  reg cnt_clr_ff;
  reg swrst_ff;
  reg load_ff;
  reg [2:0] pulse_cnt_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [15:0] presc_ff;
  reg [12:0] ms_ff;
  reg [7:0] pulse_len_ff;
  reg trig_d_ff;
  reg fault;
  reg restart;
  reg nxt_wdr_active;
  wire trig_level;
  wire trig_rise;
  wire ms_tick;
  wire wr_window;
  wire wr_output;
  wire wr_status;
  wire wr_swrst;
  wire [2:0] thr;
  wire [12:0] close_ms;
  wire [12:0] open_ms;
  wire [12:0] long_ms;
  wire blocked;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function [12:0] window_ms;
    input [1:0] kind;
    input [1:0] code;
    begin
      case ({kind, code})
        4'h0: window_ms = 13'd`WWD_CLOSE_MS_0;
        4'h1: window_ms = 13'd`WWD_CLOSE_MS_1;
        4'h2: window_ms = 13'd`WWD_CLOSE_MS_2;
        4'h3: window_ms = 13'd`WWD_CLOSE_MS_3;
        4'h4: window_ms = 13'd`WWD_OPEN_MS_0;
        4'h5: window_ms = 13'd`WWD_OPEN_MS_1;
        4'h6: window_ms = 13'd`WWD_OPEN_MS_2;
        4'h7: window_ms = 13'd`WWD_OPEN_MS_3;
        4'h8: window_ms = 13'd`WWD_LONG_MS_0;
        4'h9: window_ms = 13'd`WWD_LONG_MS_1;
        4'ha: window_ms = 13'd`WWD_LONG_MS_2;
        default: window_ms = 13'd`WWD_LONG_MS_3;
      endcase
    end
  endfunction

  function wr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = REG_WR && (addr == ofs);
    end
  endfunction

  // ----------------------------------------
  // Window lengths and threshold
  // ----------------------------------------
  // closed window lookup
  assign close_ms = window_ms(2'b00, window_cfg_ff[`WWD_CLOSE_HI:`WWD_CLOSE_LO]);
  assign open_ms = window_ms(2'b01, window_cfg_ff[`WWD_OPEN_HI:`WWD_OPEN_LO]);
  assign long_ms = window_ms(2'b10, window_cfg_ff[`WWD_LONG_HI:`WWD_LONG_LO]);
  assign thr = (window_cfg_ff[`WWD_THR_HI:`WWD_THR_LO] == 2'b11) ? 3'h4 :
               {1'b0, window_cfg_ff[`WWD_THR_HI:`WWD_THR_LO]};
  assign blocked = output_cfg_ff[`WWD_FLAGMODE_BIT] && flag_ff;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // lock gates control writes
  assign wr_window = wr_hit(REG_ADDR, `WWD_OFS_WINDOW_CFG) && !output_cfg_ff[`WWD_LOCK_BIT];
  assign wr_output = wr_hit(REG_ADDR, `WWD_OFS_OUTPUT_CFG) && !output_cfg_ff[`WWD_LOCK_BIT];
  assign wr_status = wr_hit(REG_ADDR, `WWD_OFS_STATUS);
  assign wr_swrst = wr_hit(REG_ADDR, `WWD_OFS_SWRESET);

  // ----------------------------------------
  // Trigger input
  // ----------------------------------------
  wwd_input_sync u_trig_sync (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .CE(CE),
    .PIN_IN(WATCHDOG_TRIGGER_INPUT),
    .LEVEL_OUT(trig_level)
  );

  assign trig_rise = trig_level && !trig_d_ff;

  // ----------------------------------------
  // Millisecond time base
  // ----------------------------------------
  assign ms_tick = (presc_ff == CYCLES_PER_MS[15:0] - 16'h0001);

  always @(posedge CLK_SYS) begin
    if (RST) begin
      presc_ff <= 16'h0000;
      trig_d_ff <= 1'b0;
    end else if (CE) begin
      trig_d_ff <= trig_level;
      if (ms_tick || state_ff == ST_PULSE) begin
        presc_ff <= 16'h0000;
      end else begin
        presc_ff <= presc_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Window sequencer
  // ----------------------------------------
  always @* begin
    nxt_state = state_ff;
    fault = 1'b0;
    case (state_ff)
      ST_LONG: begin
        if (trig_rise) begin
          nxt_state = ST_CLOSE;
        end else if (ms_tick && ms_ff == long_ms - 13'h0001) begin
          fault = 1'b1;
        end
      end
      ST_CLOSE: begin
        if (trig_rise) begin
          fault = 1'b1;
        end else if (ms_tick && ms_ff == close_ms - 13'h0001) begin
          nxt_state = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (trig_rise) begin
          nxt_state = ST_CLOSE;
        end else if (ms_tick && ms_ff == open_ms - 13'h0001) begin
          fault = 1'b1;
        end
      end
      ST_PULSE: begin
        if (pulse_len_ff == PULSE_CYCLES[7:0] - 8'h01) begin
          nxt_state = ST_LONG;
        end
      end
      default: begin
        nxt_state = ST_LONG;
      end
    endcase
    if (fault) begin
      nxt_state = ST_PULSE;
    end
  end

  always @* begin
    restart = fault && (thr != 3'h0) && !blocked && (pulse_cnt_ff + 3'h1 >= thr);
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      state_ff <= ST_LONG;
      ms_ff <= 13'h0000;
      pulse_len_ff <= 8'h00;
    end else if (CE) begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        ms_ff <= 13'h0000;
      end else if (ms_tick) begin
        ms_ff <= ms_ff + 13'h0001;
      end
      if (state_ff == ST_PULSE) begin
        pulse_len_ff <= pulse_len_ff + 8'h01;
      end else begin
        pulse_len_ff <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      window_cfg_ff <= `WWD_RST_WINDOW_CFG;
      output_cfg_ff <= `WWD_RST_OUTPUT_CFG;
      status_rsv_ff <= 3'h0;
      swrst_rsv_ff <= 7'h00;
      swrst_ff <= 1'b0;
      load_ff <= 1'b1;
    end else if (CE) begin
      if (swrst_ff) begin
        window_cfg_ff <= `WWD_RST_WINDOW_CFG;
        output_cfg_ff <= `WWD_RST_OUTPUT_CFG;
        status_rsv_ff <= 3'h0;
        swrst_rsv_ff <= 7'h00;
        load_ff <= 1'b1;
        swrst_ff <= 1'b0;
      end else if (load_ff) begin
        window_cfg_ff <= NV_WINDOW_CFG;
        output_cfg_ff <= {output_cfg_ff[`WWD_LOCK_BIT], NV_OUTPUT_CFG[6:0]};
        load_ff <= 1'b0;
      end else begin
        if (wr_window) begin
          window_cfg_ff <= REG_WDATA;
        end
        if (wr_output) begin
          output_cfg_ff <= {REG_WDATA[`WWD_LOCK_BIT] | output_cfg_ff[`WWD_LOCK_BIT], REG_WDATA[6:0]};
        end
        if (wr_status) begin
          status_rsv_ff <= REG_WDATA[`WWD_RSV3_HI:`WWD_RSV3_LO];
        end
        if (wr_swrst) begin
          swrst_rsv_ff <= REG_WDATA[7:1];
          swrst_ff <= REG_WDATA[`WWD_SWRST_BIT];
        end
        if (restart && output_cfg_ff[`WWD_NVRELOAD_BIT]) begin
          load_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Restart flag and pulse counter
  // ----------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      flag_ff <= 1'b0;
      flag_clr_ff <= 1'b0;
      cnt_clr_ff <= 1'b0;
      pulse_cnt_ff <= 3'h0;
    end else if (CE) begin
      // clear pulse then bit returns 0
      flag_clr_ff <= wr_status && REG_WDATA[`WWD_FLAGCLR_BIT];
      cnt_clr_ff <= wr_status && REG_WDATA[`WWD_CNTCLR_BIT];
      if (restart) begin
        flag_ff <= 1'b1;
      end else if (flag_clr_ff || swrst_ff) begin
        flag_ff <= 1'b0;
      end
      if (restart) begin
        pulse_cnt_ff <= 3'h0;
      end else if (fault) begin
        pulse_cnt_ff <= (pulse_cnt_ff == 3'h3) ? 3'h3 : pulse_cnt_ff + 3'h1;
      end else if (cnt_clr_ff || swrst_ff) begin
        pulse_cnt_ff <= 3'h0;
      end
    end
  end

  // ----------------------------------------
  // Pins and status outputs
  // ----------------------------------------
  always @* begin
    nxt_wdr_active = (nxt_state == ST_PULSE) ^ output_cfg_ff[`WWD_POL_BIT];
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      WATCHDOG_RESET_OUTPUT <= 1'b0;
      WATCHDOG_RESET_OE_N <= 1'b1;
      TRIGGER_PULLDOWN_EN <= 1'b0;
      RESTART_REQ <= 1'b0;
      NV_LOAD_REQ <= 1'b0;
      PULSE_COUNT_VALID <= 1'b1;
    end else if (CE) begin
      if (output_cfg_ff[`WWD_DRIVE_BIT]) begin
        WATCHDOG_RESET_OUTPUT <= 1'b0;
        WATCHDOG_RESET_OE_N <= nxt_wdr_active;
      end else begin
        WATCHDOG_RESET_OUTPUT <= nxt_wdr_active;
        WATCHDOG_RESET_OE_N <= 1'b0;
      end
      TRIGGER_PULLDOWN_EN <= output_cfg_ff[`WWD_PULLDOWN_BIT];
      RESTART_REQ <= restart;
      NV_LOAD_REQ <= load_ff && !swrst_ff;
      PULSE_COUNT_VALID <= (window_cfg_ff[`WWD_THR_HI:`WWD_THR_LO] == 2'b00) ||
                           (window_cfg_ff[`WWD_THR_HI:`WWD_THR_LO] == 2'b11);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (CE && REG_RD) begin
      case (REG_ADDR)
        `WWD_OFS_WINDOW_CFG: REG_RDATA <= window_cfg_ff;
        `WWD_OFS_OUTPUT_CFG: REG_RDATA <= output_cfg_ff;
        `WWD_OFS_STATUS: REG_RDATA <= {status_rsv_ff, flag_clr_ff, flag_ff, cnt_clr_ff, pulse_cnt_ff[1:0]};
        `WWD_OFS_SWRESET: REG_RDATA <= {swrst_rsv_ff, swrst_ff};
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

endmodule // window_watchdog_control

/* bench/window_watchdog_control_asserts.sv */
`timescale 1ns/1ns
module wwd_checker (
  // Clock and reset
  input wire CLK_SYS,
  input wire RST,
  input wire CE,
  // Register port
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  // Device outputs
  input wire NV_LOAD_REQ,
  input wire WATCHDOG_RESET_OUTPUT,
  input wire WATCHDOG_RESET_OE_N,
  input wire RESTART_REQ,
  input wire PULSE_COUNT_VALID
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  wire [1:0] pin = {WATCHDOG_RESET_OUTPUT, WATCHDOG_RESET_OE_N};
  wire rd_ok = REG_RD && CE && !REG_WR;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_restart_single: assert property (RESTART_REQ |=> !RESTART_REQ)
    else $error("restart request longer than one cycle");
  a_restart_pin: assert property (RESTART_REQ |-> !$stable(pin))
    else $error("restart without reset pulse on pin");
  a_pulse_hold: assert property (disable iff (RST || REG_WR) RESTART_REQ |=> $stable(pin) [*8])
    else $error("reset pulse too short");
  a_valid_code: assert property (rd_ok && REG_ADDR == 8'h1c |=>
    PULSE_COUNT_VALID == (REG_RDATA[1:0] == 2'b00 || REG_RDATA[1:0] == 2'b11))
    else $error("count valid flag wrong for threshold code");
  a_swreset_load: assert property (REG_WR && CE && REG_ADDR == 8'h1f && REG_WDATA[0] |-> ##[1:4] NV_LOAD_REQ)
    else $error("software reset without nonvolatile load");
  a_swreset_clear: assert property (rd_ok && REG_ADDR == 8'h1f && !$past(REG_WR) |=> !REG_RDATA[0])
    else $error("software reset bit stuck");
  a_status_clear: assert property (rd_ok && REG_ADDR == 8'h1e && !$past(REG_WR) |=>
    REG_RDATA[4] == 1'b0 && REG_RDATA[2] == 1'b0)
    else $error("status clear bit stuck");
  a_release_low: assert property (WATCHDOG_RESET_OE_N |-> !WATCHDOG_RESET_OUTPUT)
    else $error("released pin with output high");
  a_load_single: assert property (NV_LOAD_REQ |=> !NV_LOAD_REQ)
    else $error("load request longer than one cycle");
  c_restart: cover property (RESTART_REQ);
  c_load: cover property (NV_LOAD_REQ);
  c_status_read: cover property (rd_ok && REG_ADDR == 8'h1e);
endmodule // wwd_checker

bind window_watchdog_control wwd_checker chk_u (
  .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .NV_LOAD_REQ(NV_LOAD_REQ),
  .WATCHDOG_RESET_OUTPUT(WATCHDOG_RESET_OUTPUT), .WATCHDOG_RESET_OE_N(WATCHDOG_RESET_OE_N),
  .RESTART_REQ(RESTART_REQ), .PULSE_COUNT_VALID(PULSE_COUNT_VALID)
);

/* bench/wwd_host_model.sv */
`timescale 1ns/1ns
module wwd_host_model #(
  parameter PERIOD = 40
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Service control
  input wire serve,
  // Watchdog pins
  input wire reset_out,
  input wire reset_oe_n,
  output reg trigger,
  output reg [7:0] toggles
);
  reg [7:0] tick_ff;
  reg level_ff;
  // Board pull-up holds a released line high
  wire level = reset_oe_n ? 1'b1 : reset_out;
  always @(posedge clk) begin
    level_ff <= level;
    if (rst) begin
      tick_ff <= 8'h00;
      trigger <= 1'b0;
      toggles <= 8'h00;
    end else begin
      tick_ff <= (!serve || tick_ff == PERIOD - 1) ? 8'h00 : tick_ff + 8'h01;
      trigger <= serve && tick_ff < 8'h08;
      if (level != level_ff) begin
        toggles <= toggles + 8'h01;
      end
    end
  end
endmodule // wwd_host_model

/* bench/tb_window_watchdog_control.sv */
`timescale 1ns/1ns
module tb_window_watchdog_control;
  reg CLK_SYS = 1'b0;
  reg RST = 1'b1;
  reg REG_WR = 1'b0;
  reg REG_RD = 1'b0;
  reg serve = 1'b1;
  reg [7:0] REG_ADDR = 8'h00;
  reg [7:0] REG_WDATA = 8'h00;
  reg [7:0] NV_WINDOW_CFG = 8'h00;
  reg [7:0] NV_OUTPUT_CFG = 8'h01;
  wire [7:0] REG_RDATA;
  wire [7:0] toggles;
  wire NV_LOAD_REQ, WATCHDOG_TRIGGER_INPUT, TRIGGER_PULLDOWN_EN;
  wire WATCHDOG_RESET_OUTPUT, WATCHDOG_RESET_OE_N, RESTART_REQ, PULSE_COUNT_VALID;
  integer errors = 0;
  integer n_tests = 0;
  integer cycles = 0;
  integer n_rst = 0;
  integer n_load = 0;
  integer i, r0, t0;
  reg [31:0] rows [0:8];
  // ----------------------------------------
  // Device and host
  // ----------------------------------------
  window_watchdog_control #(.CYCLES_PER_MS(2), .PULSE_CYCLES(16)) dut_u (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(1'b1), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .NV_WINDOW_CFG(NV_WINDOW_CFG),
    .NV_OUTPUT_CFG(NV_OUTPUT_CFG), .NV_LOAD_REQ(NV_LOAD_REQ), .WATCHDOG_TRIGGER_INPUT(WATCHDOG_TRIGGER_INPUT),
    .TRIGGER_PULLDOWN_EN(TRIGGER_PULLDOWN_EN), .WATCHDOG_RESET_OUTPUT(WATCHDOG_RESET_OUTPUT),
    .WATCHDOG_RESET_OE_N(WATCHDOG_RESET_OE_N), .RESTART_REQ(RESTART_REQ), .PULSE_COUNT_VALID(PULSE_COUNT_VALID)
  );
  wwd_host_model #(.PERIOD(40)) host_u (
    .clk(CLK_SYS), .rst(RST), .serve(serve), .reset_out(WATCHDOG_RESET_OUTPUT),
    .reset_oe_n(WATCHDOG_RESET_OE_N), .trigger(WATCHDOG_TRIGGER_INPUT), .toggles(toggles)
  );
  initial begin
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    n_rst <= n_rst + (RESTART_REQ === 1'b1);
    n_load <= n_load + (NV_LOAD_REQ === 1'b1);
    if (cycles == 20000) begin
      errors = errors + 1;
      print_verdict;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge CLK_SYS);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [7:0] e);
    begin
      @(posedge CLK_SYS);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      @(posedge CLK_SYS);
      #1 check(REG_RDATA, e);
    end
  endtask
  task wait_restart(input integer lim);
    integer k;
    begin
      k = 0;
      while (RESTART_REQ !== 1'b1 && k < lim) begin
        @(posedge CLK_SYS);
        #1 k = k + 1;
      end
      check({7'h0, RESTART_REQ}, 8'h01);
    end
  endtask
  task wait_toggles(input integer n);
    integer k;
    begin
      for (k = 0; k < 1500 && toggles != n[7:0]; k = k + 1) begin
        @(posedge CLK_SYS);
      end
      @(posedge CLK_SYS);
      check(toggles, n[7:0]);
    end
  endtask
  task print_verdict;
    begin
      if (errors == 0 && n_tests > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows[0] = {8'h1c, 8'he4, 8'h1c, 8'he4};
    rows[1] = {8'h1c, 8'h03, 8'h1c, 8'h03};
    rows[2] = {8'h1d, 8'h7e, 8'h1d, 8'h7e};
    rows[3] = {8'h1d, 8'h01, 8'h1d, 8'h01};
    rows[4] = {8'h1e, 8'he0, 8'h1e, 8'he0};
    rows[5] = {8'h1e, 8'h00, 8'h1e, 8'h00};
    rows[6] = {8'h1f, 8'hfe, 8'h1f, 8'hfe};
    rows[7] = {8'h1f, 8'h00, 8'h20, 8'h00};
    rows[8] = {8'h20, 8'h55, 8'h1b, 8'h00};
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    #1 check({7'h0, PULSE_COUNT_VALID}, 8'h01);
    for (i = 0; i < 4; i = i + 1) begin
      rd_chk(8'h1c + i[7:0], (i == 1) ? 8'h01 : 8'h00);
    end
    for (i = 0; i < 9; i = i + 1) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd_chk(rows[i][15:8], rows[i][7:0]);
    end
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h1d, i[7:0]);
      repeat (2) @(posedge CLK_SYS);
      #1 check({6'h0, WATCHDOG_RESET_OUTPUT, WATCHDOG_RESET_OE_N}, i[0] ? {7'h0, i[1]} : {6'h0, i[1], 1'b0});
      check({7'h0, TRIGGER_PULLDOWN_EN}, {7'h0, i[2]});
    end
    wr(8'h1d, 8'h00);
    wr(8'h1e, 8'h14);
    wr(8'h1c, 8'h01);
    serve <= 1'b0;
    wait_restart(1000);
    repeat (20) @(posedge CLK_SYS);
    rd_chk(8'h1e, 8'h08);
    wr(8'h1e, 8'h10);
    rd_chk(8'h1e, 8'h00);
    wr(8'h1c, 8'h02);
    t0 = toggles;
    wait_toggles(t0 + 2);
    rd_chk(8'h1e, 8'h01);
    wait_restart(1000);
    repeat (20) @(posedge CLK_SYS);
    check(toggles - t0[7:0], 8'h04);
    wait_toggles(t0 + 6);
    wr(8'h1e, 8'h04);
    rd_chk(8'h1e, 8'h08);
    wr(8'h1c, 8'h01);
    wr(8'h1d, 8'h10);
    t0 = toggles;
    r0 = n_rst;
    wait_toggles(t0 + 4);
    check(n_rst - r0, 8'h00);
    wr(8'h1e, 8'h10);
    wait_restart(1000);
    NV_WINDOW_CFG <= 8'h01;
    NV_OUTPUT_CFG <= 8'h08;
    wr(8'h1d, 8'h08);
    r0 = n_load;
    wait_restart(1000);
    t0 = cycles;
    repeat (5) @(posedge CLK_SYS);
    check(n_load - r0, 8'h01);
    wr(8'h1d, 8'h00);
    r0 = n_load;
    wait_restart(1000);
    check((cycles - t0) - 32'h190, 8'h10);
    repeat (5) @(posedge CLK_SYS);
    check(n_load - r0, 8'h00);
    serve <= 1'b1;
    repeat (100) @(posedge CLK_SYS);
    wr(8'h1c, 8'h02);
    r0 = n_load;
    wr(8'h1f, 8'h01);
    repeat (3) @(posedge CLK_SYS);
    #1 check(n_load - r0, 8'h01);
    rd_chk(8'h1f, 8'h00);
    rd_chk(8'h1c, 8'h01);
    rd_chk(8'h1e, 8'h00);
    wr(8'h1d, 8'h80);
    wr(8'h1c, 8'hff);
    rd_chk(8'h1c, 8'h01);
    wr(8'h1d, 8'h00);
    rd_chk(8'h1d, 8'h80);
    wr(8'h1e, 8'he0);
    rd_chk(8'h1e, 8'he0);
    RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    rd_chk(8'h1d, 8'h08);
    print_verdict;
  end
endmodule // tb_window_watchdog_control
